// file: core/rss_pkg.sv
// Constants for the reset source supervisor: offsets, fields, reset values.
// Assumes a 100 MHz device clock and a plain one-cycle register port.
package rss_pkg;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Initial power-on pulse, least width
   localparam int unsigned POR_MIN_NS = 150;
   localparam int unsigned POR_CYC = (POR_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned POR_CNT_W = 5;

   // Precise low-voltage reset re-arm hold-off
   localparam int unsigned PLV_HOLD_US = 10;
   localparam int unsigned PLV_HOLD_CYC = PLV_HOLD_US * CLK_MHZ;
   localparam int unsigned PLV_HOLD_W = 10;

   // Monitor buzz on-time in sleep
   localparam int unsigned BUZZ_ON_CYC = 8;
   localparam int unsigned BUZZ_ON_W = 3;
   localparam int unsigned BUZZ_W = 16;
   localparam int unsigned WDT_W = 24;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TRIP = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_BUZZ = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SWRST = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_WDT_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_WDT_PER = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_WDT_KICK = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;

   // Control fields
   localparam int unsigned CTRL_W = 8;
   localparam int unsigned CTRL_SWBLK = 0;
   localparam int unsigned CTRL_ANA = 1;
   localparam int unsigned CTRL_ARST = 2;
   localparam int unsigned CTRL_DRST = 3;
   localparam int unsigned CTRL_AEN = 4;
   localparam int unsigned CTRL_DEN = 5;
   localparam int unsigned CTRL_HEN = 6;
   localparam int unsigned CTRL_BOOST = 7;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h02;

   // Trip codes: 1.70 V plus 250 mV per step; high trip fixed at 5.75 V
   localparam int unsigned LVL_W = 4;
   localparam int unsigned TRIP_DIG_LSB = 0;
   localparam int unsigned TRIP_ANA_LSB = 4;
   localparam logic [2*LVL_W-1:0] TRIP_RST = 8'h00;

   localparam logic [BUZZ_W-1:0] BUZZ_RST = 16'h0400;
   localparam logic [WDT_W-1:0] WDT_PER_RST = 24'h0F_4240;
   localparam int unsigned SWRST_BIT = 0;
   localparam int unsigned WDT_EN_BIT = 0;

   // Status fields
   localparam int unsigned ST_W = 7;
   localparam int unsigned ST_PLV = 0;
   localparam int unsigned ST_SW = 1;
   localparam int unsigned ST_WDT = 2;
   localparam int unsigned ST_EXT = 3;
   localparam int unsigned ST_DLV = 4;
   localparam int unsigned ST_ALV = 5;
   localparam int unsigned ST_AHV = 6;
endpackage : rss_pkg

// file: core/rss_supervisor.sv
// Reset source supervisor: merges power-on, precise low-voltage, pin,
// software and watchdog resets. Assumes analog monitors deliver clocked levels.
`timescale 1ns/1ps

// Functional notes
// - Power-on pulse lasts at least 150 ns and stretches while supplies ramp.
// - After boot, power-on monitor stops; precise low-voltage monitor takes over.
// - Precise low-voltage trip gives a system reset; unlike power-on, it keeps status and watchdog enable.
// - Digital precise monitor cannot be disabled; analog part follows analog regulator.
// - Precise monitor off in sleep and hibernate, except during sleep buzz.
// - Precise reset waits 10 us after release before it may assert again.
// - Low-voltage trips programmable in 250 mV steps; high trip fixed 5.75 V.
// - Each low-voltage monitor can also reset the device; its status bit still raises the interrupt.
// - Voltage interrupt monitors stay off until power-on reset completes.
// - Buzz-time interrupt first wakes the device, then is recognised.
// - Pin held low keeps the device in power-on style reset; the code gives a system reset that keeps status and watchdog enable.
// - Reset pin works in sleep and hibernate.
// - Software reset bit write, processor or DMA, gives power-on style reset; the code gives a system reset that keeps status and watchdog enable.
// - A control bit blocks the software reset bit.
// - Watchdog not serviced within programmed interval causes reset.
// - Watchdog off after power-on; once enabled stays on until power-on.
// - Status register records causes and interrupts; cleared by power-on.
// - System reset returns all registers except status and watchdog enable to their reset state.
// - Supply monitors can interrupt before reset thresholds are reached.
// - Boost in sleep: chip wakes periodically for boost refresh.
module rss_supervisor (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [rss_pkg::ADDR_W-1:0] addr_i,
   input wire logic [rss_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [rss_pkg::DATA_W-1:0] rdata_o,
   input wire logic supply_ramping_i,
   input wire logic boot_done_i,
   input wire logic plv_dig_trip_i,
   input wire logic plv_ana_trip_i,
   input wire logic sleep_i,
   input wire logic hibernate_i,
   input wire logic digital_lv_trip_i,
   input wire logic analog_lv_trip_i,
   input wire logic analog_hv_trip_i,
   input wire logic external_reset_n_i,
   output logic system_reset_o,
   output logic por_monitor_en_o,
   output logic plv_dig_en_o,
   output logic plv_ana_en_o,
   output logic lv_monitor_en_o,
   output logic buzz_o,
   output logic [rss_pkg::LVL_W-1:0] digital_lv_level_o,
   output logic [rss_pkg::LVL_W-1:0] analog_lv_level_o,
   output logic lvi_irq_o,
   output logic wake_req_o,
   output logic boost_refresh_o
);
   import rss_pkg::*;

   logic por_active_r;
   logic [POR_CNT_W-1:0] por_cnt_r;
   logic boot_r;
   logic plv_req_r;
   logic [PLV_HOLD_W-1:0] plv_hold_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [2*LVL_W-1:0] trip_r;
   logic [BUZZ_W-1:0] buzz_per_r;
   logic [BUZZ_W-1:0] buzz_cnt_r;
   logic buzz_r;
   logic [BUZZ_ON_W-1:0] buzz_on_r;
   logic wdt_en_r;
   logic [WDT_W-1:0] wdt_per_r;
   logic [WDT_W-1:0] wdt_cnt_r;
   logic [ST_W-1:0] status_r;
   logic [ST_W-1:0] status_nxt;
   logic sys_rst_r;
   logic [DATA_W-1:0] rdata_r;
   logic power_on;
   logic awake;
   logic mon_en;
   logic plv_en;
   logic plv_raw;
   logic sw_pulse;
   logic wdt_kick;
   logic wdt_exp;
   logic dlv_ev;
   logic alv_ev;
   logic ahv_ev;
   logic lv_rst;
   logic reset_req;

   assign power_on = rst_i | por_active_r;
   assign awake = ~sleep_i & ~hibernate_i;

   // Power-on pulse, stretched while ramping
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         por_active_r <= 1'b1;
         por_cnt_r <= '0;
      end
      else if (por_active_r && supply_ramping_i)
      begin
         por_cnt_r <= '0;
      end
      else if (por_active_r)
      begin
         if (por_cnt_r == POR_CNT_W'(POR_CYC - 1))
            por_active_r <= 1'b0;
         else
            por_cnt_r <= por_cnt_r + 1'b1;
      end
   end

   // Boot hand-off
   always_ff @(posedge clock_i)
   begin
      if (power_on)
         boot_r <= 1'b0;
      else if (boot_done_i)
         boot_r <= 1'b1;
   end

   assign por_monitor_en_o = ~boot_r;
   assign plv_en = boot_r & (awake | buzz_r);
   assign plv_dig_en_o = plv_en;
   assign plv_ana_en_o = plv_en & ctrl_r[CTRL_ANA];
   assign plv_raw = plv_en & (plv_dig_trip_i | (ctrl_r[CTRL_ANA] & plv_ana_trip_i));

   // Precise low-voltage reset with re-arm hold-off
   always_ff @(posedge clock_i)
   begin
      if (power_on)
      begin
         plv_req_r <= 1'b0;
         plv_hold_r <= '0;
      end
      else if (plv_req_r)
      begin
         if (!plv_raw)
         begin
            plv_req_r <= 1'b0;
            plv_hold_r <= PLV_HOLD_W'(PLV_HOLD_CYC - 1);
         end
      end
      else if (plv_hold_r != '0)
         plv_hold_r <= plv_hold_r - 1'b1;
      else if (plv_raw)
         plv_req_r <= 1'b1;
   end

   // Voltage interrupt monitors
   assign mon_en = ~por_active_r & (awake | buzz_r);
   assign lv_monitor_en_o = mon_en;
   assign digital_lv_level_o = trip_r[TRIP_DIG_LSB +: LVL_W];
   assign analog_lv_level_o = trip_r[TRIP_ANA_LSB +: LVL_W];
   assign dlv_ev = mon_en & ctrl_r[CTRL_DEN] & digital_lv_trip_i;
   assign alv_ev = mon_en & ctrl_r[CTRL_AEN] & analog_lv_trip_i;
   assign ahv_ev = mon_en & ctrl_r[CTRL_HEN] & analog_hv_trip_i;
   assign lv_rst = (dlv_ev & ctrl_r[CTRL_DRST]) | (alv_ev & ctrl_r[CTRL_ARST]);

   // Software reset and watchdog service
   assign sw_pulse = wr_i & (addr_i == OFS_SWRST) & wdata_i[SWRST_BIT]
      & ~ctrl_r[CTRL_SWBLK];
   assign wdt_kick = wr_i & (addr_i == OFS_WDT_KICK);
   assign wdt_exp = wdt_en_r & (wdt_cnt_r >= wdt_per_r);

   // Merged reset: immediate assert, clocked release
   assign reset_req = por_active_r | plv_req_r | ~external_reset_n_i | sw_pulse
      | wdt_exp | lv_rst;
   assign system_reset_o = reset_req | sys_rst_r;

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         sys_rst_r <= 1'b1;
      else
         sys_rst_r <= reset_req;
   end

   // Control registers, reset by any system reset
   always_ff @(posedge clock_i)
   begin
      if (rst_i || system_reset_o)
      begin
         ctrl_r <= CTRL_RST;
         trip_r <= TRIP_RST;
         buzz_per_r <= BUZZ_RST;
         wdt_per_r <= WDT_PER_RST;
      end
      else if (wr_i)
      begin
         if (addr_i == OFS_CTRL)
            ctrl_r <= wdata_i[CTRL_W-1:0];
         if (addr_i == OFS_TRIP)
            trip_r <= wdata_i[2*LVL_W-1:0];
         if (addr_i == OFS_BUZZ)
            buzz_per_r <= wdata_i[BUZZ_W-1:0];
         if (addr_i == OFS_WDT_PER)
            wdt_per_r <= wdata_i[WDT_W-1:0];
      end
   end

   // Watchdog enable, cleared only by power-on
   always_ff @(posedge clock_i)
   begin
      if (power_on)
         wdt_en_r <= 1'b0;
      else if (wr_i && addr_i == OFS_WDT_CTRL && wdata_i[WDT_EN_BIT])
         wdt_en_r <= 1'b1;
   end

   // Watchdog counter
   always_ff @(posedge clock_i)
   begin
      if (rst_i || system_reset_o || wdt_kick || !wdt_en_r)
         wdt_cnt_r <= '0;
      else
         wdt_cnt_r <= wdt_cnt_r + 1'b1;
   end

   // Sleep buzz timer
   always_ff @(posedge clock_i)
   begin
      if (rst_i || system_reset_o || !sleep_i || hibernate_i)
      begin
         buzz_cnt_r <= '0;
         buzz_r <= 1'b0;
         buzz_on_r <= '0;
      end
      else if (buzz_r)
      begin
         if (buzz_on_r == BUZZ_ON_W'(BUZZ_ON_CYC - 1))
         begin
            buzz_r <= 1'b0;
            buzz_on_r <= '0;
         end
         else
            buzz_on_r <= buzz_on_r + 1'b1;
      end
      else if (buzz_cnt_r >= buzz_per_r)
      begin
         buzz_cnt_r <= '0;
         buzz_r <= 1'b1;
      end
      else
         buzz_cnt_r <= buzz_cnt_r + 1'b1;
   end

   assign buzz_o = buzz_r;
   assign boost_refresh_o = buzz_r & ctrl_r[CTRL_BOOST];

   // Status: set wins over write-one-to-clear
   always_comb
   begin
      status_nxt = status_r;
      if (wr_i && addr_i == OFS_STATUS)
         status_nxt = status_r & ~wdata_i[ST_W-1:0];
      status_nxt[ST_PLV] = status_nxt[ST_PLV] | plv_req_r;
      status_nxt[ST_SW] = status_nxt[ST_SW] | sw_pulse;
      status_nxt[ST_WDT] = status_nxt[ST_WDT] | wdt_exp;
      status_nxt[ST_EXT] = status_nxt[ST_EXT] | ~external_reset_n_i;
      status_nxt[ST_DLV] = status_nxt[ST_DLV] | dlv_ev;
      status_nxt[ST_ALV] = status_nxt[ST_ALV] | alv_ev;
      status_nxt[ST_AHV] = status_nxt[ST_AHV] | ahv_ev;
   end

   always_ff @(posedge clock_i)
   begin
      if (power_on)
         status_r <= '0;
      else
         status_r <= status_nxt;
   end

   // Interrupt recognised only once awake
   assign wake_req_o = sleep_i & (|status_r[ST_AHV:ST_DLV]);
   assign lvi_irq_o = awake & (|status_r[ST_AHV:ST_DLV]);

   // Read port
   always_ff @(posedge clock_i)
   begin
      if (rst_i || !rd_i)
         rdata_r <= '0;
      else
      begin
         case (addr_i)
            OFS_CTRL: rdata_r <= DATA_W'(ctrl_r);
            OFS_TRIP: rdata_r <= DATA_W'(trip_r);
            OFS_BUZZ: rdata_r <= DATA_W'(buzz_per_r);
            OFS_WDT_CTRL: rdata_r <= DATA_W'(wdt_en_r);
            OFS_WDT_PER: rdata_r <= DATA_W'(wdt_per_r);
            OFS_STATUS: rdata_r <= DATA_W'(status_r);
            default: rdata_r <= '0;
         endcase
      end
   end

   assign rdata_o = rdata_r;

   // Checks
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   property p_por_width;
      $fell(por_active_r) |-> $past(por_cnt_r) == POR_CNT_W'(POR_CYC - 1);
   endproperty
   a_por_width: assert property (p_por_width) else $error("power-on pulse short");

   property p_plv_after_boot;
      !boot_r |-> !plv_req_r && !plv_dig_en_o;
   endproperty
   a_plv_after_boot: assert property (p_plv_after_boot) else $error("precise early");

   property p_plv_reset;
      plv_req_r |-> system_reset_o ##1 system_reset_o;
   endproperty
   a_plv_reset: assert property (p_plv_reset) else $error("precise no reset");

   property p_plv_sleep;
      (sleep_i || hibernate_i) && !buzz_r |-> !plv_dig_en_o;
   endproperty
   a_plv_sleep: assert property (p_plv_sleep) else $error("precise on in sleep");

   property p_plv_hold;
      $fell(plv_req_r) && !power_on |-> !plv_req_r [*8] ##0
         plv_hold_r == PLV_HOLD_W'(PLV_HOLD_CYC - 8);
   endproperty
   a_plv_hold: assert property (p_plv_hold) else $error("precise hold-off");

   property p_lv_reset;
      dlv_ev && ctrl_r[CTRL_DRST] |-> system_reset_o ##1 sys_rst_r;
   endproperty
   a_lv_reset: assert property (p_lv_reset) else $error("low-voltage reset lost");

   property p_mon_off;
      por_active_r |-> !lv_monitor_en_o && !lvi_irq_o;
   endproperty
   a_mon_off: assert property (p_mon_off) else $error("monitor before power-on");

   property p_irq_wake;
      sleep_i |-> !lvi_irq_o;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("irq while asleep");

   property p_pin;
      !external_reset_n_i |-> system_reset_o ##1 system_reset_o;
   endproperty
   a_pin: assert property (p_pin) else $error("pin reset lost");

   property p_sw;
      wr_i && addr_i == OFS_SWRST && wdata_i[SWRST_BIT] && !ctrl_r[CTRL_SWBLK]
         |-> system_reset_o ##1 status_r[ST_SW];
   endproperty
   a_sw: assert property (p_sw) else $error("software reset lost");

   property p_sw_block;
      ctrl_r[CTRL_SWBLK] |-> !sw_pulse;
   endproperty
   a_sw_block: assert property (p_sw_block) else $error("blocked reset fired");

   property p_wdt_sticky;
      wdt_en_r && !por_active_r |=> wdt_en_r;
   endproperty
   a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog cleared");

   property p_release;
      $fell(reset_req) |-> system_reset_o;
   endproperty
   a_release: assert property (p_release) else $error("early release");

   c_por_done: cover property ($fell(por_active_r));
   c_plv_trip: cover property ($rose(plv_req_r));
   c_wdt_fire: cover property (wdt_exp);
   c_lv_irq: cover property ($rose(lvi_irq_o));
endmodule : rss_supervisor

// file: sim/rss_pin_drv.sv
// Model of the outside driver of the reset pin; pin pulled up when released.
// Assumes the bench asks for a low pulse by holding hold_i.
`timescale 1ns/1ps
module rss_pin_drv (
   input wire logic clock_i,
   input wire logic hold_i,
   output logic external_reset_n_o
);
   int guard_cnt = 0;
   initial external_reset_n_o = 1'b1;
   always @(posedge clock_i)
   begin
      if (hold_i && guard_cnt == 0)
         external_reset_n_o <= 1'b0;
      else if (!external_reset_n_o && !hold_i)
      begin
         external_reset_n_o <= 1'b1;
         guard_cnt <= 1000;
      end
      else if (guard_cnt > 0)
         guard_cnt <= guard_cnt - 1;
   end
endmodule : rss_pin_drv

// file: sim/tb_top.sv
// Self-checking bench for the reset source supervisor.
// Assumes a 100 MHz clock and the one-cycle register port of the design.
`timescale 1ns/1ps
module tb_top;
   import rss_pkg::*;
   logic clock_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, ramp = 0, boot = 1, plv_trip = 0;
   logic sleep_i = 0, hib = 0, hold = 0, pin_n, sys_rst, por_en, plv_en, plv_a_en, lv_en;
   logic buzz, irq, wake, boost, plv_atrip = 0;
   logic [2:0] lv_trip = 3'b000;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata;
   logic [LVL_W-1:0] dig_lvl, ana_lvl;
   int error_cnt = 0, compares = 0, n, i;
   logic [7:0] ctl_irq [3] = '{8'h22, 8'h12, 8'h42};
   int st_bit [3] = '{ST_DLV, ST_ALV, ST_AHV};
   always #5 clock_i = ~clock_i;
   rss_pin_drv pin_u (.clock_i(clock_i), .hold_i(hold), .external_reset_n_o(pin_n));
   rss_supervisor dut_u (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .supply_ramping_i(ramp), .boot_done_i(boot),
      .plv_dig_trip_i(plv_trip), .plv_ana_trip_i(plv_atrip), .sleep_i(sleep_i),
      .hibernate_i(hib), .digital_lv_trip_i(lv_trip[0]), .analog_lv_trip_i(lv_trip[1]),
      .analog_hv_trip_i(lv_trip[2]), .external_reset_n_i(pin_n), .system_reset_o(sys_rst),
      .por_monitor_en_o(por_en), .plv_dig_en_o(plv_en), .plv_ana_en_o(plv_a_en),
      .lv_monitor_en_o(lv_en), .buzz_o(buzz), .digital_lv_level_o(dig_lvl),
      .analog_lv_level_o(ana_lvl), .lvi_irq_o(irq), .wake_req_o(wake),
      .boost_refresh_o(boost));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      addr <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd
   task wait_for(input int sel, input logic v, input int lim);
      int k;
      k = 0;
      while (((sel == 0) ? sys_rst : buzz) !== v && k < lim)
      begin
         @(posedge clock_i);
         #1;
         k++;
      end
      chk((sel == 0) ? sys_rst : buzz, v);
   endtask : wait_for
   task step(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask : step
   task wrap_up;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      wrap_up;
   end
   initial
   begin
      step(4);
      chk(lv_en, 0);
      rst_i <= 1'b0;
      n = 0;
      step(1);
      while (sys_rst === 1'b1 && n < 200)
      begin
         step(1);
         n++;
      end
      chk(32'(n >= POR_CYC), 1);
      chk(por_en, 0);
      chk(lv_en, 1);
      chk(plv_a_en, 1);
      @(posedge clock_i);
      rst_i <= 1'b1;
      ramp <= 1'b1;
      step(2);
      rst_i <= 1'b0;
      step(40);
      chk(sys_rst, 1);
      ramp <= 1'b0;
      wait_for(0, 0, 100);
      rd(OFS_CTRL, 32'(CTRL_RST));
      rd(OFS_BUZZ, 32'(BUZZ_RST));
      rd(OFS_WDT_PER, 32'(WDT_PER_RST));
      rd(OFS_STATUS, 0);
      rd(OFS_WDT_CTRL, 0);
      rd(8'h20, 0);
      $display("test power_on done");
      wr(OFS_CTRL, 32'h01);
      wr(OFS_SWRST, 1);
      chk(sys_rst, 0);
      wr(OFS_CTRL, 32'h00);
      chk({plv_en, plv_a_en}, 2'b10);
      plv_atrip <= 1'b1;
      step(2);
      chk(sys_rst, 0);
      plv_atrip <= 1'b0;
      wr(OFS_SWRST, 1);
      chk(sys_rst, 1);
      wait_for(0, 0, 50);
      rd(OFS_CTRL, 32'(CTRL_RST));
      rd(OFS_STATUS, 32'(1) << ST_SW);
      wr(OFS_STATUS, 32'h7F);
      rd(OFS_STATUS, 0);
      $display("test software done");
      wr(OFS_TRIP, 32'h5A);
      chk(32'(dig_lvl), 32'h0A);
      chk(32'(ana_lvl), 32'h05);
      @(posedge clock_i);
      plv_atrip <= 1'b1;
      step(3);
      chk(sys_rst, 1);
      plv_atrip <= 1'b0;
      wait_for(0, 0, 50);
      rd(OFS_TRIP, 0);
      rd(OFS_STATUS, 32'(1) << ST_PLV);
      plv_trip <= 1'b1;
      step(900);
      chk(sys_rst, 0);
      wait_for(0, 1, 200);
      plv_trip <= 1'b0;
      wait_for(0, 0, 50);
      wr(OFS_STATUS, 32'h7F);
      $display("test precise done");
      for (i = 0; i < 3; i++)
      begin
         wr(OFS_CTRL, 32'(ctl_irq[i]));
         lv_trip[i] <= 1'b1;
         step(1);
         lv_trip[i] <= 1'b0;
         step(2);
         chk(irq, 1);
         sleep_i <= 1'b1;
         step(1);
         chk({irq, wake}, 2'b01);
         sleep_i <= 1'b0;
         rd(OFS_STATUS, 32'(1) << st_bit[i]);
         wr(OFS_STATUS, 32'h7F);
         step(1);
         chk(irq, 0);
      end
      for (i = 0; i < 2; i++)
      begin
         wr(OFS_CTRL, (i == 0) ? 32'h2A : 32'h16);
         lv_trip[i] <= 1'b1;
         step(1);
         chk(sys_rst, 1);
         lv_trip[i] <= 1'b0;
         wait_for(0, 0, 50);
         rd(OFS_STATUS, 32'(1) << st_bit[i]);
         wr(OFS_STATUS, 32'h7F);
      end
      $display("test monitors done");
      sleep_i <= 1'b1;
      hold <= 1'b1;
      step(3);
      chk(sys_rst, 1);
      hold <= 1'b0;
      sleep_i <= 1'b0;
      wait_for(0, 0, 50);
      rd(OFS_STATUS, 32'(1) << ST_EXT);
      wr(OFS_STATUS, 32'h7F);
      $display("test pin done");
      wr(OFS_BUZZ, 16);
      wr(OFS_CTRL, 32'h82);
      sleep_i <= 1'b1;
      step(2);
      chk(plv_en, 0);
      wait_for(1, 1, 40);
      chk({plv_en, boost}, 2'b11);
      wr(OFS_CTRL, 32'h02);
      sleep_i <= 1'b0;
      hib <= 1'b1;
      step(2);
      chk(plv_en, 0);
      hib <= 1'b0;
      $display("test buzz done");
      wr(OFS_WDT_PER, 20);
      wr(OFS_WDT_CTRL, 1);
      repeat (3)
      begin
         step(8);
         wr(OFS_WDT_KICK, 0);
      end
      chk(sys_rst, 0);
      wait_for(0, 1, 40);
      wait_for(0, 0, 50);
      rd(OFS_STATUS, 32'(1) << ST_WDT);
      wr(OFS_WDT_CTRL, 0);
      rd(OFS_WDT_CTRL, 1);
      $display("test watchdog done");
      wrap_up;
   end
endmodule : tb_top
